// file: bmc_regs.vh
/*
 Register map, field positions, reset values and timing of the barometer
 measurement control block. Assumes a 100 MHz core clock.
*/
// Function
// - Threshold is 16-bit unsigned, high byte 0Dh, low byte 0Ch, hPa times sixteen.
// - Threshold events need differential enable and high or low event enable.
// - High enable flags pressure above threshold, low enable flags pressure below.
// - Rate field: 000 off/one-shot, then 1, 10, 25, 50, 75 Hz.
// - Power-down keeps interface and configuration, output data holds last sample.
// - Single-conversion bit in power-down measures once, updates, self-clears, powers down.
// - Single conversion starts only if already in power-down at trigger write.
// - Nonzero rate acquires pressure and temperature continuously at that rate.
// - Bandwidth is rate over 2, or over 9 or 20 with filter on.
// - Block data update freezes outputs after a sample until 2Ah is read.
// - Wire-mode bit: 0 selects 4-wire, 1 selects 3-wire; default 0.
// - At power-up trimming values are copied from flash automatically.
// - Trim-reload bit recopies trimming after one rate clock, then self-clears.
// - Control two holds FIFO enable and stop-at-watermark bits, both default 0.
// - Auto-increment, default 1, advances the address after each byte.
// - Software reset restores 0Bh-0Dh, 10h-12h, 14h-17h defaults, then self-clears; the core has and restores only 0Bh-0Dh, 10h and 11h.
`ifndef BMC_REGS_VH
`define BMC_REGS_VH

`define BMC_ADDR_IRQ_CFG 7'h0b
`define BMC_ADDR_THS_L 7'h0c
`define BMC_ADDR_THS_H 7'h0d
`define BMC_ADDR_IDENTITY 7'h0f
`define BMC_ADDR_CTRL1 7'h10
`define BMC_ADDR_CTRL2 7'h11
`define BMC_ADDR_STATUS 7'h27
`define BMC_ADDR_P_XL 7'h28
`define BMC_ADDR_P_L 7'h29
`define BMC_ADDR_P_H 7'h2a
`define BMC_ADDR_T_L 7'h2b
`define BMC_ADDR_T_H 7'h2c

// Interrupt configuration bits
`define BMC_DIFFERENTIAL_IRQ_ENABLE 3
`define BMC_PLE 1
`define BMC_PHE 0
// Control one bits
`define BMC_RATE_HI 6
`define BMC_RATE_LO 4
`define BMC_LPF_EN 3
`define BMC_LPF_CFG 2
`define BMC_BDU 1
`define BMC_SIM 0
// Control two bits
`define BMC_BOOT 7
`define BMC_FIFO_EN 6
`define BMC_STOP_FTH 5
`define BMC_ADD_INC 4
`define BMC_TWO_WIRE_DISABLE 3
`define BMC_SOFT_RESET_BIT 2
`define BMC_ONE_SHOT 0

`define BMC_CTRL1_RESET 8'h00
`define BMC_CTRL2_RESET 8'h10
`define BMC_ZERO_RESET 8'h00

// Rate codes and rates
`define BMC_RATE_OFF 3'h0
`define BMC_RATE_1 3'h1
`define BMC_RATE_10 3'h2
`define BMC_RATE_25 3'h3
`define BMC_RATE_50 3'h4
`define BMC_RATE_75 3'h5
`define BMC_CLK_HZ 100000000
`define BMC_HZ_1 1
`define BMC_HZ_10 10
`define BMC_HZ_25 25
`define BMC_HZ_50 50
`define BMC_HZ_75 75
// Conversion time of one pressure and temperature set
`define BMC_CONV_TIME_US 20

// Bandwidth divisors
`define BMC_BW_DIV_OFF 5'h02
`define BMC_BW_DIV_9 5'h09
`define BMC_BW_DIV_20 5'h14

`endif

// file: bmc_core.v
/*
 Measurement control of the barometer: serial register port (SPI mode 3,
 4-wire or 3-wire), configuration registers, rate timer, one-shot and
 continuous acquisition, block data update, threshold events, trim reload.
 Assumes the sensing front end delivers a sample on sensor_pressure and
 sensor_temperature, on core_clk, when a conversion ends.
*/
`include "bmc_regs.vh"

module bmc_core #(
	parameter PERIOD_1 = `BMC_CLK_HZ / `BMC_HZ_1,
	parameter PERIOD_10 = `BMC_CLK_HZ / `BMC_HZ_10,
	parameter PERIOD_25 = `BMC_CLK_HZ / `BMC_HZ_25,
	parameter PERIOD_50 = `BMC_CLK_HZ / `BMC_HZ_50,
	parameter PERIOD_75 = `BMC_CLK_HZ / `BMC_HZ_75,
	parameter BOOT_CYCLES = `BMC_CLK_HZ / `BMC_HZ_75,
	parameter CONV_CYCLES = `BMC_CONV_TIME_US * (`BMC_CLK_HZ / 1000000),
	// Arbitrary identity value
	parameter [7:0] IDENTITY = 8'h5a
) (
	input wire core_clk,
	input wire reset_n,
	input wire ce,
	input wire spc,
	input wire cs_n,
	input wire sdio_in,
	output wire sdio_out,
	output wire sdio_oe_n,
	output wire sdo_out,
	output wire sdo_oe_n,
	input wire [23:0] sensor_pressure,
	input wire [15:0] sensor_temperature,
	output reg conv_start,
	output reg trim_load,
	output reg [4:0] filter_divisor,
	output wire fifo_enable,
	output wire stop_at_watermark,
	output wire two_wire_disable,
	output reg pressure_high_event,
	output reg pressure_low_event
);

	// Serial pin synchronisers
	reg [2:0] spc_s;
	reg [1:0] cs_s;
	reg [1:0] din_s;
	wire spc_rise = spc_s[1] & ~spc_s[2];
	wire spc_fall = ~spc_s[1] & spc_s[2];
	wire sel = ~cs_s[1];

	// Serial engine
	reg [2:0] bit_cnt;
	reg [6:0] in_sh;
	reg [6:0] addr;
	reg have_cmd;
	reg is_read;
	reg load_req;
	reg hold_first;
	reg [6:0] out_addr;
	reg drive;
	reg [7:0] out_sh;
	reg wr_stb;
	reg [7:0] wr_data;
	reg [7:0] rd_data;
	wire [7:0] new_byte = {in_sh, din_s[1]};

	// Configuration
	reg differential_irq_enable;
	reg high_event_enable;
	reg low_event_enable;
	reg [7:0] threshold_low_byte;
	reg [7:0] threshold_high_byte;
	reg [2:0] rate_select;
	reg pressure_filter_enable;
	reg filter_bandwidth_select;
	reg block_data_update;
	reg spi_wire_mode;
	reg fifo_en;
	reg stop_fth;
	reg auto_inc;
	reg i2c_off;
	reg one_shot;

	// Measurement and boot
	reg [26:0] rate_cnt;
	reg [15:0] conv_cnt;
	reg busy;
	reg boot_go;
	reg boot_busy;
	reg [26:0] boot_cnt;
	reg [23:0] pressure_high_byte_all;
	reg [15:0] temp_out;
	reg p_avail;
	reg t_avail;
	reg bdu_lock;

	wire conv_done = busy && (conv_cnt == CONV_CYCLES[15:0] - 16'h0001);
	wire os_go = one_shot & ~busy & (rate_select == `BMC_RATE_OFF);
	// A byte counts as read when its first bit is clocked out, not at prefetch
	wire took_byte = sel && spc_fall && hold_first;
	wire rd_p_h = took_byte && (out_addr == `BMC_ADDR_P_H);
	wire rd_t_h = took_byte && (out_addr == `BMC_ADDR_T_H);
	localparam [7:0] CTRL1_DEF = `BMC_CTRL1_RESET;
	localparam [7:0] CTRL2_DEF = `BMC_CTRL2_RESET;
	wire cfg_wr = wr_stb && (addr == `BMC_ADDR_CTRL2);
	wire soft_rst = cfg_wr && wr_data[`BMC_SOFT_RESET_BIT];
	wire [16:0] ths_pos = {1'b0, threshold_high_byte, threshold_low_byte};
	wire signed [16:0] p_diff = {sensor_pressure[23], sensor_pressure[23:8]};
	wire rate_tick;

	// Cycles per sample for a rate code; zero means no periodic acquisition
	function [26:0] rate_period;
		input [2:0] code;
		begin
			case (code)
				`BMC_RATE_1: rate_period = PERIOD_1[26:0];
				`BMC_RATE_10: rate_period = PERIOD_10[26:0];
				`BMC_RATE_25: rate_period = PERIOD_25[26:0];
				`BMC_RATE_50: rate_period = PERIOD_50[26:0];
				`BMC_RATE_75: rate_period = PERIOD_75[26:0];
				default: rate_period = 27'h0000000;
			endcase
		end
	endfunction

	assign rate_tick = (rate_period(rate_select) != 27'h0000000) &&
		(rate_cnt >= rate_period(rate_select) - 27'h0000001);

	assign sdo_out = out_sh[7];
	assign sdio_out = out_sh[7];
	assign sdo_oe_n = ~(drive & ~spi_wire_mode);
	assign sdio_oe_n = ~(drive & spi_wire_mode);
	assign fifo_enable = fifo_en;
	assign stop_at_watermark = stop_fth;
	assign two_wire_disable = i2c_off;

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			spc_s <= 3'h7;
			cs_s <= 2'h3;
			din_s <= 2'h0;
		end else if (ce) begin
			spc_s <= {spc_s[1:0], spc};
			cs_s <= {cs_s[0], cs_n};
			din_s <= {din_s[0], sdio_in};
		end
	end

	// Serial interface stays alive in every rate, power-down included
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			bit_cnt <= 3'h0;
			in_sh <= 7'h00;
			addr <= 7'h00;
			have_cmd <= 1'b0;
			is_read <= 1'b0;
			load_req <= 1'b0;
			hold_first <= 1'b0;
			out_addr <= 7'h00;
			drive <= 1'b0;
			out_sh <= 8'h00;
			wr_stb <= 1'b0;
			wr_data <= 8'h00;
		end else if (ce) begin
			load_req <= 1'b0;
			wr_stb <= 1'b0;
			if (load_req) begin
				out_sh <= rd_data;
				out_addr <= addr;
				hold_first <= 1'b1;
				drive <= 1'b1;
			end
			if ((load_req | wr_stb) && auto_inc)
				addr <= addr + 7'h01;
			if (!sel) begin
				bit_cnt <= 3'h0;
				have_cmd <= 1'b0;
				is_read <= 1'b0;
				hold_first <= 1'b0;
				drive <= 1'b0;
			end else if (spc_rise) begin
				in_sh <= new_byte[6:0];
				bit_cnt <= bit_cnt + 3'h1;
				if (bit_cnt == 3'h7) begin
					if (!have_cmd) begin
						have_cmd <= 1'b1;
						is_read <= new_byte[7];
						addr <= new_byte[6:0];
						load_req <= new_byte[7];
					end else if (is_read) begin
						load_req <= 1'b1;
					end else begin
						wr_stb <= 1'b1;
						wr_data <= new_byte;
					end
				end
			end else if (spc_fall) begin
				// First bit already sits on the pin after the load
				if (hold_first)
					hold_first <= 1'b0;
				else
					out_sh <= {out_sh[6:0], 1'b0};
			end
		end
	end

	// Reserved bits and unmapped addresses read as zero
	always @* begin
		rd_data = 8'h00;
		case (addr)
			`BMC_ADDR_IRQ_CFG: begin
				rd_data[`BMC_DIFFERENTIAL_IRQ_ENABLE] = differential_irq_enable;
				rd_data[`BMC_PLE] = low_event_enable;
				rd_data[`BMC_PHE] = high_event_enable;
			end
			`BMC_ADDR_THS_L: rd_data = threshold_low_byte;
			`BMC_ADDR_THS_H: rd_data = threshold_high_byte;
			`BMC_ADDR_IDENTITY: rd_data = IDENTITY;
			`BMC_ADDR_CTRL1: begin
				rd_data[`BMC_RATE_HI:`BMC_RATE_LO] = rate_select;
				rd_data[`BMC_LPF_EN] = pressure_filter_enable;
				rd_data[`BMC_LPF_CFG] = filter_bandwidth_select;
				rd_data[`BMC_BDU] = block_data_update;
				rd_data[`BMC_SIM] = spi_wire_mode;
			end
			`BMC_ADDR_CTRL2: begin
				rd_data[`BMC_BOOT] = boot_busy | boot_go;
				rd_data[`BMC_FIFO_EN] = fifo_en;
				rd_data[`BMC_STOP_FTH] = stop_fth;
				rd_data[`BMC_ADD_INC] = auto_inc;
				rd_data[`BMC_TWO_WIRE_DISABLE] = i2c_off;
				rd_data[`BMC_ONE_SHOT] = one_shot;
			end
			`BMC_ADDR_STATUS: rd_data = {6'h00, t_avail, p_avail};
			`BMC_ADDR_P_XL: rd_data = pressure_high_byte_all[7:0];
			`BMC_ADDR_P_L: rd_data = pressure_high_byte_all[15:8];
			`BMC_ADDR_P_H: rd_data = pressure_high_byte_all[23:16];
			`BMC_ADDR_T_L: rd_data = temp_out[7:0];
			`BMC_ADDR_T_H: rd_data = temp_out[15:8];
			default: rd_data = 8'h00;
		endcase
	end

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			differential_irq_enable <= 1'b0;
			high_event_enable <= 1'b0;
			low_event_enable <= 1'b0;
			threshold_low_byte <= `BMC_ZERO_RESET;
			threshold_high_byte <= `BMC_ZERO_RESET;
			rate_select <= `BMC_RATE_OFF;
			pressure_filter_enable <= 1'b0;
			filter_bandwidth_select <= 1'b0;
			block_data_update <= 1'b0;
			spi_wire_mode <= 1'b0;
			fifo_en <= 1'b0;
			stop_fth <= 1'b0;
			auto_inc <= 1'b1;
			i2c_off <= 1'b0;
			one_shot <= 1'b0;
		end else if (ce) begin
			if (conv_done)
				one_shot <= 1'b0;
			if (soft_rst) begin
				differential_irq_enable <= 1'b0;
				high_event_enable <= 1'b0;
				low_event_enable <= 1'b0;
				threshold_low_byte <= `BMC_ZERO_RESET;
				threshold_high_byte <= `BMC_ZERO_RESET;
				rate_select <= CTRL1_DEF[`BMC_RATE_HI:`BMC_RATE_LO];
				pressure_filter_enable <= CTRL1_DEF[`BMC_LPF_EN];
				filter_bandwidth_select <= CTRL1_DEF[`BMC_LPF_CFG];
				block_data_update <= CTRL1_DEF[`BMC_BDU];
				spi_wire_mode <= CTRL1_DEF[`BMC_SIM];
				fifo_en <= CTRL2_DEF[`BMC_FIFO_EN];
				stop_fth <= CTRL2_DEF[`BMC_STOP_FTH];
				auto_inc <= CTRL2_DEF[`BMC_ADD_INC];
				i2c_off <= CTRL2_DEF[`BMC_TWO_WIRE_DISABLE];
				one_shot <= 1'b0;
			end else if (wr_stb) begin
				case (addr)
					`BMC_ADDR_IRQ_CFG: begin
						differential_irq_enable <= wr_data[`BMC_DIFFERENTIAL_IRQ_ENABLE];
						low_event_enable <= wr_data[`BMC_PLE];
						high_event_enable <= wr_data[`BMC_PHE];
					end
					`BMC_ADDR_THS_L: threshold_low_byte <= wr_data;
					`BMC_ADDR_THS_H: threshold_high_byte <= wr_data;
					`BMC_ADDR_CTRL1: begin
						// Bit 7 is not stored; host keeps it zero
						rate_select <= wr_data[`BMC_RATE_HI:`BMC_RATE_LO];
						pressure_filter_enable <= wr_data[`BMC_LPF_EN];
						filter_bandwidth_select <= wr_data[`BMC_LPF_CFG];
						block_data_update <= wr_data[`BMC_BDU];
						spi_wire_mode <= wr_data[`BMC_SIM];
					end
					`BMC_ADDR_CTRL2: begin
						fifo_en <= wr_data[`BMC_FIFO_EN];
						stop_fth <= wr_data[`BMC_STOP_FTH];
						auto_inc <= wr_data[`BMC_ADD_INC];
						i2c_off <= wr_data[`BMC_TWO_WIRE_DISABLE];
						// Trigger only counts from power-down; set beats done-clear
						if (wr_data[`BMC_ONE_SHOT] && rate_select == `BMC_RATE_OFF && !busy)
							one_shot <= 1'b1;
					end
					default: ;
				endcase
			end
		end
	end

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			boot_go <= 1'b1;
			boot_busy <= 1'b0;
			boot_cnt <= 27'h0000000;
			trim_load <= 1'b0;
		end else if (ce) begin
			trim_load <= 1'b0;
			if (boot_go) begin
				boot_go <= 1'b0;
				boot_busy <= 1'b1;
				boot_cnt <= 27'h0000000;
				trim_load <= 1'b1;
			end else if (boot_busy) begin
				boot_cnt <= boot_cnt + 27'h0000001;
				if (boot_cnt == BOOT_CYCLES[26:0] - 27'h0000001)
					boot_busy <= 1'b0;
			end
			if (cfg_wr && !soft_rst && wr_data[`BMC_BOOT])
				boot_go <= 1'b1;
		end
	end

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rate_cnt <= 27'h0000000;
			conv_cnt <= 16'h0000;
			busy <= 1'b0;
			conv_start <= 1'b0;
		end else if (ce) begin
			conv_start <= 1'b0;
			if (rate_tick || rate_select == `BMC_RATE_OFF)
				rate_cnt <= 27'h0000000;
			else
				rate_cnt <= rate_cnt + 27'h0000001;
			// A tick during a conversion is dropped, not queued
			if (!busy && (rate_tick || os_go)) begin
				busy <= 1'b1;
				conv_cnt <= 16'h0000;
				conv_start <= 1'b1;
			end else if (busy) begin
				conv_cnt <= conv_cnt + 16'h0001;
				if (conv_done)
					busy <= 1'b0;
			end
		end
	end

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pressure_high_byte_all <= 24'h000000;
			temp_out <= 16'h0000;
			p_avail <= 1'b0;
			t_avail <= 1'b0;
			bdu_lock <= 1'b0;
			pressure_high_event <= 1'b0;
			pressure_low_event <= 1'b0;
			filter_divisor <= `BMC_BW_DIV_OFF;
		end else if (ce) begin
			if (!pressure_filter_enable)
				filter_divisor <= `BMC_BW_DIV_OFF;
			else if (filter_bandwidth_select)
				filter_divisor <= `BMC_BW_DIV_20;
			else
				filter_divisor <= `BMC_BW_DIV_9;
			if (rd_p_h)
				p_avail <= 1'b0;
			if (rd_t_h)
				t_avail <= 1'b0;
			if (rd_p_h || !block_data_update)
				bdu_lock <= 1'b0;
			// Outputs move only at a conversion end, so power-down holds them
			if (conv_done) begin
				p_avail <= 1'b1;
				t_avail <= 1'b1;
				pressure_high_event <= differential_irq_enable & high_event_enable &
					(p_diff > $signed(ths_pos));
				pressure_low_event <= differential_irq_enable & low_event_enable &
					(p_diff < -$signed(ths_pos));
				if (!(block_data_update && bdu_lock && !rd_p_h)) begin
					pressure_high_byte_all <= sensor_pressure;
					temp_out <= sensor_temperature;
					bdu_lock <= block_data_update;
				end
			end
		end
	end

endmodule

// file: bmc_checker.sv
/*
 Port checker for bmc_core, bound to every instance.
 Assumes one core clock domain and the asynchronous active-low reset.
*/
module bmc_checker #(
	parameter CONV_CYCLES = 2000
) (
	input wire core_clk,
	input wire reset_n,
	input wire ce,
	input wire cs_n,
	input wire sdio_out,
	input wire sdio_oe_n,
	input wire sdo_out,
	input wire sdo_oe_n,
	input wire conv_start,
	input wire trim_load,
	input wire [4:0] filter_divisor,
	input wire fifo_enable,
	input wire stop_at_watermark,
	input wire two_wire_disable,
	input wire pressure_high_event,
	input wire pressure_low_event
);
	logic [31:0] since_start;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	// Age of the latest conversion; events may move only at its end
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			since_start <= 32'h0;
		end else if (conv_start) begin
			since_start <= 32'h0;
		end else if (since_start != 32'hffffffff) begin
			since_start <= since_start + 32'h1;
		end
	end

	sequence s_no_start;
		!conv_start [*8];
	endsequence
	sequence s_bus_idle;
		cs_n [*8];
	endsequence

	chk_oe_exclusive: assert property (sdo_oe_n || sdio_oe_n)
		else $error("both data pins enabled");
	chk_pins_same: assert property (sdo_out == sdio_out)
		else $error("data pins differ");
	chk_oe_release: assert property ($rose(cs_n) |-> ##[1:6] (sdo_oe_n && sdio_oe_n))
		else $error("data pin held after deselect");
	chk_conv_single: assert property (conv_start |=> s_no_start)
		else $error("conversion restarted too soon");
	chk_trim_pulse: assert property (trim_load |=> !trim_load)
		else $error("trim load longer than one cycle");
	chk_trim_boot: assert property ($rose(reset_n) && ce |=> trim_load)
		else $error("no trim load after reset");
	chk_divisor_legal: assert property (filter_divisor inside {5'h02, 5'h09, 5'h14})
		else $error("bandwidth divisor illegal");
	chk_events_exclusive: assert property (!(pressure_high_event && pressure_low_event))
		else $error("high and low events together");
	chk_event_timing: assert property ($changed({pressure_high_event, pressure_low_event})
		|-> since_start inside {[CONV_CYCLES - 2:CONV_CYCLES + 3]})
		else $error("event moved outside a conversion end");
	chk_config_held: assert property (s_bus_idle |=> $stable({fifo_enable,
		stop_at_watermark, two_wire_disable, filter_divisor}))
		else $error("configuration changed without access");
endmodule

bind bmc_core bmc_checker #(.CONV_CYCLES(CONV_CYCLES)) u_bmc_checker (.core_clk, .reset_n,
	.ce, .cs_n, .sdio_out, .sdio_oe_n, .sdo_out, .sdo_oe_n, .conv_start, .trim_load,
	.filter_divisor, .fifo_enable, .stop_at_watermark, .two_wire_disable,
	.pressure_high_event, .pressure_low_event);

// file: bmc_host_model.sv
/*
 Host SPI master model, mode 3, 125 ns serial clock.
 Assumes the bench routes the read line to match the wire mode it selected.
*/
module bmc_host_model (
	output logic spc,
	output logic cs_n,
	output logic mosi,
	input wire logic miso
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		spc = 1'b1;
		cs_n = 1'b1;
		mosi = 1'b1;
	end

	// Data moves on the fall; both ends sample on the rise
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			#62.5 spc = 1'b0;
			mosi = tx[i];
			#62.5 spc = 1'b1;
			rx[i] = miso;
		end
	endtask

	task automatic access(input logic rd, input logic [6:0] adr, input int n,
		input logic [31:0] wd, output logic [31:0] rdat);
		logic [7:0] b;
		rdat = 32'h0;
		cs_n = 1'b0;
		xfer({rd, adr}, b);
		for (int k = 0; k < n; k++) begin
			// Toggling filler while reading: the pin value must not matter
			xfer(rd ? 8'h55 : wd[8*k+:8], b);
			rdat[8*k+:8] = b;
		end
		#100 cs_n = 1'b1;
		mosi = ~mosi;
		#300;
	endtask
endmodule

// file: baro_measurement_control_tb_top.sv
/*
 Self-checking bench of the barometer measurement control block.
 Assumes the host model as register master and a bench-driven sensor front end.
*/
`include "bmc_regs.vh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin errors++; \
	$display("[FAIL] %s expected %h seen %h", nm, ex, got); end end

module baro_measurement_control_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int PER [1:5] = '{200, 100, 80, 60, 50};
	localparam int CONV = 10;
	localparam logic [7:0] IDENT = 8'h3c; // Arbitrary identity value
	localparam logic [7:0] CFG [4] = '{8'h09, 8'h0a, 8'h03, 8'h0b};
	logic core_clk, reset_n, ce, spc, cs_n, mosi, three;
	logic [23:0] sens_p;
	logic [15:0] sens_t;
	wire logic sdio_in, miso, sdio_out, sdio_oe_n, sdo_out, sdo_oe_n, conv_start, trim_load;
	wire logic fifo_en, stop_wm, two_dis, hi_ev, lo_ev;
	wire logic [4:0] fdiv_o;
	int errors, num_checks, nconv, ntrim, cyc, tprev, tlast;

	assign sdio_in = !sdio_oe_n ? sdio_out : mosi;
	assign miso = three ? sdio_in : sdo_out;

	bmc_core #(.PERIOD_1(200), .PERIOD_10(100), .PERIOD_25(80), .PERIOD_50(60),
		.PERIOD_75(50), .BOOT_CYCLES(20), .CONV_CYCLES(CONV), .IDENTITY(IDENT)) dut (
		.core_clk(core_clk), .reset_n(reset_n), .ce(ce), .spc(spc), .cs_n(cs_n),
		.sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .sdo_out(sdo_out),
		.sdo_oe_n(sdo_oe_n), .sensor_pressure(sens_p), .sensor_temperature(sens_t),
		.conv_start(conv_start), .trim_load(trim_load), .filter_divisor(fdiv_o),
		.fifo_enable(fifo_en), .stop_at_watermark(stop_wm), .two_wire_disable(two_dis),
		.pressure_high_event(hi_ev), .pressure_low_event(lo_ev));
	bmc_host_model h (.spc(spc), .cs_n(cs_n), .mosi(mosi), .miso(miso));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (conv_start) begin
			nconv <= nconv + 1;
			tprev <= tlast;
			tlast <= cyc;
		end
		if (trim_load) ntrim <= ntrim + 1;
	end

	task automatic close_out;
		if (errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	function automatic logic [4:0] fdiv(logic [1:0] b);
		return !b[1] ? `BMC_BW_DIV_OFF : (b[0] ? `BMC_BW_DIV_20 : `BMC_BW_DIV_9);
	endfunction

	function automatic logic [1:0] ev_exp(logic [7:0] c, logic [15:0] t, logic [15:0] p);
		ev_exp[1] = c[3] & c[0] & ($signed(p) > $signed({1'b0, t}));
		ev_exp[0] = c[3] & c[1] & ($signed(p) < -$signed({1'b0, t}));
	endfunction

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [31:0] r;
		if (a == `BMC_ADDR_CTRL1) d[7] = 1'b0;
		if (a == `BMC_ADDR_CTRL2) d[1] = 1'b0;
		h.access(1'b0, a, 1, {24'h0, d}, r);
	endtask

	task automatic rdc(input logic [6:0] a, input logic [7:0] ex);
		logic [31:0] r;
		h.access(1'b1, a, 1, 32'h0, r);
		`CHK($sformatf("reg %h", a), ex, r[7:0])
	endtask

	task automatic oneshot(input logic [23:0] v);
		int n0;
		@(posedge core_clk) sens_p <= v;
		sens_t <= 16'($urandom);
		n0 = nconv;
		wr(`BMC_ADDR_CTRL2, 8'h11);
		repeat (CONV + 10) @(posedge core_clk);
		`CHK("one conversion", n0 + 1, nconv)
		rdc(`BMC_ADDR_CTRL2, 8'h10);
	endtask

	initial begin
		logic [7:0] c;
		logic [15:0] thr, p;
		logic [23:0] a;
		logic [31:0] r;
		int n0;
		reset_n = 1'b0;
		ce = 1'b1;
		three = 1'b0;
		sens_p = 24'h0;
		sens_t = 16'h0;
		void'($urandom(32'h09bde4d4));
		repeat (3) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (40) @(posedge core_clk);
		`CHK("boot loads", 1, ntrim)
		rdc(`BMC_ADDR_THS_L, 8'h00);
		rdc(`BMC_ADDR_THS_H, 8'h00);
		rdc(`BMC_ADDR_IDENTITY, IDENT);
		rdc(`BMC_ADDR_CTRL1, 8'h00);
		rdc(`BMC_ADDR_CTRL2, 8'h10);
		rdc(7'h0e, 8'h00);
		for (int i = 0; i < 4; i++) begin
			c = {1'b0, 2'($urandom), 1'b1, 1'($urandom), 3'b000};
			wr(`BMC_ADDR_CTRL2, c);
			wr(`BMC_ADDR_CTRL1, {4'h0, 2'(i), 2'b00});
			`CHK("filter", fdiv(2'(i)), fdiv_o)
			`CHK("config", c[6:3], {fifo_en, stop_wm, 1'b1, two_dis})
			rdc(`BMC_ADDR_CTRL2, c);
		end
		wr(`BMC_ADDR_CTRL2, 8'h00);
		h.access(1'b0, `BMC_ADDR_THS_L, 2, 32'h0000bbaa, r);
		rdc(`BMC_ADDR_THS_L, 8'hbb);
		rdc(`BMC_ADDR_THS_H, 8'h00);
		wr(`BMC_ADDR_CTRL2, 8'h10);
		for (int i = 0; i < 4; i++) begin
			c = CFG[i];
			thr = 16'($urandom_range(1, 16'h3fff));
			p = i[0] ? -thr - 16'd1 : thr + 16'($urandom_range(1, 255));
			wr(`BMC_ADDR_IRQ_CFG, c);
			h.access(1'b0, `BMC_ADDR_THS_L, 2, {16'h0, thr}, r);
			rdc(`BMC_ADDR_THS_H, thr[15:8]);
			oneshot({p, 8'($urandom)});
			`CHK("events", ev_exp(c, thr, p), {hi_ev, lo_ev})
		end
		a = 24'($urandom);
		oneshot(a);
		@(posedge core_clk) sens_p <= ~a;
		n0 = nconv;
		repeat (400) @(posedge core_clk);
		`CHK("idle", n0, nconv)
		wr(`BMC_ADDR_CTRL2, 8'h00);
		rdc(`BMC_ADDR_P_XL, a[7:0]);
		rdc(`BMC_ADDR_P_L, a[15:8]);
		rdc(`BMC_ADDR_P_H, a[23:16]);
		for (int k = 1; k <= 5; k++) begin
			wr(`BMC_ADDR_CTRL1, {1'b0, 3'(k), 4'h0});
			wr(`BMC_ADDR_CTRL2, 8'h11);
			repeat (3 * PER[k]) @(posedge core_clk);
			`CHK("rate period", PER[k], tlast - tprev)
			rdc(`BMC_ADDR_CTRL2, 8'h10);
		end
		wr(`BMC_ADDR_CTRL1, 8'h00);
		h.access(1'b1, `BMC_ADDR_P_H, 1, 32'h0, r);
		a = 24'($urandom);
		@(posedge core_clk) sens_p <= a;
		wr(`BMC_ADDR_CTRL1, 8'h12);
		repeat (500) @(posedge core_clk);
		@(posedge core_clk) sens_p <= ~a;
		repeat (500) @(posedge core_clk);
		rdc(`BMC_ADDR_P_L, a[15:8]);
		rdc(`BMC_ADDR_P_H, a[23:16]);
		repeat (500) @(posedge core_clk);
		rdc(`BMC_ADDR_P_L, ~a[15:8]);
		wr(`BMC_ADDR_CTRL1, 8'h01);
		three = 1'b1;
		rdc(`BMC_ADDR_IDENTITY, IDENT);
		three = 1'b0;
		wr(`BMC_ADDR_CTRL1, 8'h00);
		n0 = ntrim;
		wr(`BMC_ADDR_CTRL2, 8'h90);
		repeat (40) @(posedge core_clk);
		`CHK("reload", n0 + 1, ntrim)
		rdc(`BMC_ADDR_CTRL2, 8'h10);
		// Freeze after a finished conversion; no tick may land while frozen
		wr(`BMC_ADDR_CTRL1, 8'h10);
		@(posedge conv_start);
		repeat (CONV + 2) @(posedge core_clk);
		ce <= 1'b0;
		n0 = nconv;
		repeat (600) @(posedge core_clk);
		`CHK("frozen", n0, nconv)
		ce <= 1'b1;
		repeat (300) @(posedge core_clk);
		`CHK("thawed", n0 + 1, nconv)
		wr(`BMC_ADDR_IRQ_CFG, 8'h0b);
		wr(`BMC_ADDR_CTRL1, 8'h0c);
		wr(`BMC_ADDR_CTRL2, 8'h04);
		rdc(`BMC_ADDR_IRQ_CFG, 8'h00);
		rdc(`BMC_ADDR_THS_H, 8'h00);
		rdc(`BMC_ADDR_CTRL1, 8'h00);
		rdc(`BMC_ADDR_CTRL2, 8'h10);
		close_out();
	end

	initial begin
		#900000;
		errors++;
		close_out();
	end
endmodule
